// ### hdl/ocr_ctrl.sv
// Output clock routing control: byte registers, source selection and output gating.
// Operation
// - Two-bit selector picks each output's source.
// - Output selectors reset to 10, 00, 11.
// - Divider one source field, resets to 01.
// - Chip power-down bit, low powers down.
// - Reference free-run bit, resets to stop.
// - Free-run configuration for third, stop enable for first.
// - Output-enable pin function enable, reset off.
// - Divider four source field, resets to 11.
// - Register 22h reserved with given resets.
`timescale 1ns/1ps
module ocr_ctrl (
   // Clock and reset
   input  wire  logic             ref_clk,
   input  wire  logic             nrst,
   // Byte register port from the serial engine
   input  wire  logic [7:0]       reg_addr,
   input  wire  logic [7:0]       reg_wdata,
   input  wire  logic             reg_wr,
   input  wire  logic             reg_rd,
   output logic       [7:0]       reg_rdata,
   // Clock sources
   input  wire  logic             pll1_clk,
   input  wire  logic             ref_in_clk,
   input  wire  logic             divider_four_seed_out,
   input  wire  logic             pll_two_channel_two,
   input  wire  logic             pll_three_channel_two,
   input  wire  logic             divider_three_seed,
   input  wire  logic             divider_five_seed,
   input  wire  logic             divider_one,
   input  wire  logic             divider_three,
   input  wire  logic             divider_five,
   input  wire  logic             low_power_rtc_clock,
   // Pins
   input  wire  logic             oe2_pin,
   input  wire  logic             oe3_pin,
   input  wire  logic             stop_req_pin,
   // Divider source clocks
   output wire  logic             divider_one_src,
   output wire  logic             divider_four_src,
   // Output clocks
   output wire  logic             first_output,
   output wire  logic             second_output,
   output wire  logic             third_output,
   // Configuration
   output ocr_pkg::ocr_cfg_t      cfg,
   output wire  logic             chip_power_down_n
);
   import ocr_pkg::*;

   logic [7:0] rsvd_a_reg;
   logic [7:0] outsel_reg;
   logic [7:0] pwrdiv_reg;
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic       en1_reg;
   logic       en2_reg;
   logic       en3_reg;
   logic [7:0] rdata_next;
   logic       en1_next;
   logic       en2_next;
   logic       en3_next;

   wire logic hit_rsvd;
   wire logic hit_outsel;
   wire logic hit_pwrdiv;
   wire logic oe2_s;
   wire logic oe3_s;
   wire logic stop_s;
   wire logic ref_on_divider_one;
   wire logic second_is_ref;
   wire logic third_is_ref;
   wire logic first_src;
   wire logic second_src;
   wire logic third_src;

   assign hit_rsvd   = reg_addr == OCR_RSVD_A_OFS;
   assign hit_outsel = reg_addr == OCR_OUTSEL_OFS;
   assign hit_pwrdiv = reg_addr == OCR_PWRDIV_OFS;

   // Reserved register is stored so that read-modify-write by the host round-trips.
   // reserved register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rsvd_a_reg <= OCR_RSVD_A_RST;
      end else if (reg_wr && hit_rsvd) begin
         rsvd_a_reg <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         outsel_reg <= OCR_OUTSEL_RST;
      end else if (reg_wr && hit_outsel) begin
         outsel_reg <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pwrdiv_reg <= OCR_PWRDIV_RST;
      end else if (reg_wr && hit_pwrdiv) begin
         pwrdiv_reg <= reg_wdata;
      end
   end

   always_comb begin
      if (hit_rsvd) begin
         rdata_next = rsvd_a_reg;
      end else if (hit_outsel) begin
         rdata_next = outsel_reg;
      end else if (hit_pwrdiv) begin
         rdata_next = pwrdiv_reg;
      end else begin
         rdata_next = OCR_UNMAPPED_RD;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= OCR_UNMAPPED_RD;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end
   end

   assign cfg.third_sel                  = outsel_reg[OCR_THIRD_SEL_LSB +: 2];
   assign cfg.second_sel                 = outsel_reg[OCR_SECOND_SEL_LSB +: 2];
   assign cfg.first_sel                  = outsel_reg[OCR_FIRST_SEL_LSB +: 2];
   assign cfg.divider_one_sel            = outsel_reg[OCR_DIVIDER_ONE_SEL_LSB +: 2];
   assign cfg.chip_power_down_n          = pwrdiv_reg[OCR_PDN_BIT];
   assign cfg.ref_free_run               = pwrdiv_reg[OCR_REF_FREE_BIT];
   assign cfg.both_free_run              = pwrdiv_reg[OCR_BOTH_FREE_BIT];
   assign cfg.first_output_stoppable     = pwrdiv_reg[OCR_FIRST_STOP_BIT];
   assign cfg.enable_pin_function_enable = pwrdiv_reg[OCR_PIN_EN_BIT];
   assign cfg.divider_four_sel           = pwrdiv_reg[OCR_DIVIDER_FOUR_SEL_LSB +: 2];
   assign chip_power_down_n              = cfg.chip_power_down_n;

   // Pins are asynchronous; two stages before the gating logic reads them.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
      end else begin
         sync1_reg <= {stop_req_pin, oe3_pin, oe2_pin};
         sync2_reg <= sync1_reg;
      end
   end

   assign oe2_s  = sync2_reg[0];
   assign oe3_s  = sync2_reg[1];
   assign stop_s = sync2_reg[2];

   ocr_src_mux #(.W(1)) u_divider_one_mux (
      .sel  (cfg.divider_one_sel),
      .src0 (pll1_clk),
      .src1 (ref_in_clk),
      .src2 (divider_four_seed_out),
      .src3 (divider_four_seed_out),
      .out  (divider_one_src)
   );

   ocr_src_mux #(.W(1)) u_divider_four_mux (
      .sel  (cfg.divider_four_sel),
      .src0 (pll_two_channel_two),
      .src1 (pll_three_channel_two),
      .src2 (divider_three_seed),
      .src3 (divider_five_seed),
      .out  (divider_four_src)
   );

   ocr_src_mux #(.W(1)) u_first_mux (
      .sel  (cfg.first_sel),
      .src0 (divider_three),
      .src1 (divider_five),
      .src2 (divider_one),
      .src3 (low_power_rtc_clock),
      .out  (first_src)
   );
   ocr_src_mux #(.W(1)) u_second_mux (
      .sel  (cfg.second_sel),
      .src0 (divider_three),
      .src1 (divider_five),
      .src2 (divider_one),
      .src3 (low_power_rtc_clock),
      .out  (second_src)
   );
   ocr_src_mux #(.W(1)) u_third_mux (
      .sel  (cfg.third_sel),
      .src0 (divider_three),
      .src1 (divider_five),
      .src2 (divider_one),
      .src3 (low_power_rtc_clock),
      .out  (third_src)
   );

   assign ref_on_divider_one = cfg.divider_one_sel == OCR_D1_REF;
   assign second_is_ref      = ref_on_divider_one && (cfg.second_sel == OCR_OUT_DIVIDER_ONE);
   assign third_is_ref       = ref_on_divider_one && (cfg.third_sel == OCR_OUT_DIVIDER_ONE);

   // Enables change only on ref_clk edges; the output clocks are gated plainly,
   // so a slow ref_clk trades exact stop timing for a simple structure.
   always_comb begin
      en1_next = cfg.chip_power_down_n && !(stop_s && cfg.first_output_stoppable);
      en2_next = cfg.chip_power_down_n
                 && (!cfg.enable_pin_function_enable || oe2_s)
                 && !(second_is_ref && stop_s && !cfg.ref_free_run);
      en3_next = cfg.chip_power_down_n
                 && (!cfg.enable_pin_function_enable || oe3_s)
                 && !(stop_s && !cfg.both_free_run)
                 && !(third_is_ref && stop_s && !cfg.ref_free_run);
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         en1_reg <= 1'b0;
         en2_reg <= 1'b0;
         en3_reg <= 1'b0;
      end else begin
         en1_reg <= en1_next;
         en2_reg <= en2_next;
         en3_reg <= en3_next;
      end
   end

   assign first_output  = first_src && en1_reg;
   assign second_output = second_src && en2_reg;
   assign third_output  = third_src && en3_reg;

   out_mux_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (cfg.second_sel == OCR_OUT_RTC) |-> (second_src == low_power_rtc_clock))
      else $error("second output not on low power clock");
   sel_reset_a: assert property (@(posedge ref_clk)
      $rose(nrst) |-> (outsel_reg == OCR_OUTSEL_RST))
      else $error("output selectors wrong after reset");
   seed_route_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      cfg.divider_one_sel[1] |-> (divider_one_src == divider_four_seed_out))
      else $error("divider one not on seed");
   power_down_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!cfg.chip_power_down_n [*2]) |-> !(en1_reg || en2_reg || en3_reg))
      else $error("output running in power down");
   ref_stop_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (second_is_ref && stop_s && !cfg.ref_free_run) |=> !en2_reg)
      else $error("reference not stopped on second output");
   third_free_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (stop_s && !cfg.both_free_run) |=> !en3_reg)
      else $error("third output not stopped");
   pin_func_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (cfg.enable_pin_function_enable && !oe2_s) |=> !en2_reg)
      else $error("second output ignores enable pin");
   four_route_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (cfg.divider_four_sel == 2'h2) |-> (divider_four_src == divider_three_seed))
      else $error("divider four not on divider three seed");
   rsvd_reset_a: assert property (@(posedge ref_clk)
      $rose(nrst) |-> (rsvd_a_reg == OCR_RSVD_A_RST && pwrdiv_reg == OCR_PWRDIV_RST))
      else $error("reserved or power register reset wrong");
   write_take_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (reg_wr && hit_outsel) |=> (outsel_reg == $past(reg_wdata)))
      else $error("output select write lost");

endmodule : ocr_ctrl

// ### hdl/ocr_pkg.sv
// Package for the output clock routing control block: offsets, resets, codes and types.
package ocr_pkg;

   // Register byte offsets.
   localparam logic [7:0] OCR_RSVD_A_OFS  = 8'h22;
   localparam logic [7:0] OCR_OUTSEL_OFS  = 8'h23;
   localparam logic [7:0] OCR_PWRDIV_OFS  = 8'h24;

   // Reset values; unused bit 4 of power_freerun_divsel resets to one.
   localparam logic [7:0] OCR_RSVD_A_RST  = 8'h84;
   localparam logic [7:0] OCR_OUTSEL_RST  = 8'h8D;
   localparam logic [7:0] OCR_PWRDIV_RST  = 8'h9B;
   localparam logic [7:0] OCR_UNMAPPED_RD = 8'h00;

   // Field positions in output_source_select.
   localparam int OCR_THIRD_SEL_LSB  = 6;
   localparam int OCR_SECOND_SEL_LSB = 4;
   localparam int OCR_FIRST_SEL_LSB  = 2;
   localparam int OCR_DIVIDER_ONE_SEL_LSB = 0;

   // Field positions in power_freerun_divsel.
   localparam int OCR_PDN_BIT        = 7;
   localparam int OCR_REF_FREE_BIT   = 6;
   localparam int OCR_BOTH_FREE_BIT  = 5;
   localparam int OCR_FIRST_STOP_BIT = 3;
   localparam int OCR_PIN_EN_BIT     = 2;
   localparam int OCR_DIVIDER_FOUR_SEL_LSB = 0;

   // Output selector codes.
   localparam logic [1:0] OCR_OUT_DIVIDER_THREE = 2'h0;
   localparam logic [1:0] OCR_OUT_DIVIDER_FIVE  = 2'h1;
   localparam logic [1:0] OCR_OUT_DIVIDER_ONE   = 2'h2;
   localparam logic [1:0] OCR_OUT_RTC    = 2'h3;

   // Divider one source codes (upper bit set selects the seed).
   localparam logic [1:0] OCR_D1_PLL1    = 2'h0;
   localparam logic [1:0] OCR_D1_REF     = 2'h1;

   // Configuration seen by the clock gating logic.
   typedef struct packed {
      logic [1:0] third_sel;
      logic [1:0] second_sel;
      logic [1:0] first_sel;
      logic [1:0] divider_one_sel;
      logic       chip_power_down_n;
      logic       ref_free_run;
      logic       both_free_run;
      logic       first_output_stoppable;
      logic       enable_pin_function_enable;
      logic [1:0] divider_four_sel;
   } ocr_cfg_t;

endpackage : ocr_pkg

// ### hdl/ocr_src_mux.sv
// Four-way clock source selector.
`timescale 1ns/1ps
module ocr_src_mux #(
   parameter int W = 1
) (
   // Select code
   input  wire logic [1:0]   sel,
   // Sources
   input  wire logic [W-1:0] src0,
   input  wire logic [W-1:0] src1,
   input  wire logic [W-1:0] src2,
   input  wire logic [W-1:0] src3,
   // Selected source
   output wire logic [W-1:0] out
);
   wire logic [W-1:0] low_pick;
   wire logic [W-1:0] high_pick;

   assign low_pick  = sel[0] ? src1 : src0;
   assign high_pick = sel[0] ? src3 : src2;
   assign out       = sel[1] ? high_pick : low_pick;
endmodule : ocr_src_mux

// ### test/ocr_host_model.sv
// Management host model that reads and writes the byte registers.
`timescale 1ns/1ps
module ocr_host_model (
   // Clock
   input  wire logic       ref_clk,
   // Register port
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_wr = 1'b0;
      // Released data never keeps its last value.
      reg_wdata = ~d;
   endtask : wr_byte

   task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask : rd_byte

   task automatic rmw_byte(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
      logic [7:0] cur;
      rd_byte(a, cur);
      wr_byte(a, (cur & ~m) | (v & m));
   endtask : rmw_byte
endmodule : ocr_host_model

// ### test/output_clock_routing_ctrl_test.sv
// Self-checking bench for the output clock routing control block.
`timescale 1ns/1ps
module output_clock_routing_ctrl_test;
   import ocr_pkg::*;
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
   logic ref_clk = 1'b0;
   logic nrst;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   logic reg_wr, reg_rd, oe2, oe3, stp;
   logic [10:0] src;
   logic d1s, d4s, o1, o2, o3, pdn;
   ocr_cfg_t cfg;
   int fails = 0;
   int cmp_count = 0;
   int omap[4] = '{8, 9, 7, 10};
   int d1map[4] = '{0, 1, 2, 2};
   int d4map[4] = '{3, 4, 5, 6};

   always #50 ref_clk = ~ref_clk;

   ocr_host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   ocr_ctrl dut_u (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pll1_clk(src[0]), .ref_in_clk(src[1]), .divider_four_seed_out(src[2]),
      .pll_two_channel_two(src[3]), .pll_three_channel_two(src[4]),
      .divider_three_seed(src[5]), .divider_five_seed(src[6]), .divider_one(src[7]),
      .divider_three(src[8]), .divider_five(src[9]), .low_power_rtc_clock(src[10]),
      .oe2_pin(oe2), .oe3_pin(oe3), .stop_req_pin(stp), .divider_one_src(d1s),
      .divider_four_src(d4s), .first_output(o1), .second_output(o2), .third_output(o3),
      .cfg(cfg), .chip_power_down_n(pdn));

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   task automatic chk_out(input logic [2:0] e);
      `CHK("outputs", e, {o3, o2, o1})
   endtask : chk_out

   task automatic t_reset;
      host_u.rd_byte(OCR_RSVD_A_OFS, rd);
      `CHK("reg22", OCR_RSVD_A_RST, rd)
      host_u.rd_byte(OCR_OUTSEL_OFS, rd);
      `CHK("reg23", 8'h8D, rd)
      `CHK("divider one sel", OCR_D1_REF, cfg.divider_one_sel)
      host_u.rd_byte(OCR_PWRDIV_OFS, rd);
      `CHK("reg24", 8'h9B, rd)
      `CHK("pdn pin", 1'b1, pdn)
      host_u.wr_byte(8'h25, 8'hFF);
      host_u.rd_byte(8'h25, rd);
      `CHK("unmapped", OCR_UNMAPPED_RD, rd)
      host_u.rd_byte(OCR_OUTSEL_OFS, rd);
      `CHK("reg23 kept", 8'h8D, rd)
   endtask : t_reset

   task automatic t_select;
      for (int c = 0; c < 4; c++) begin
         host_u.wr_byte(OCR_OUTSEL_OFS, {4{c[1:0]}});
         host_u.rmw_byte(OCR_PWRDIV_OFS, 8'h03, {6'h00, c[1:0]});
         src = (11'h001 << omap[c]) | (11'h001 << d1map[c]) | (11'h001 << d4map[c]);
         tick(2);
         chk_out(3'h7);
         `CHK("divider one src", 1'b1, d1s)
         `CHK("divider four src", 1'b1, d4s)
         `CHK("third sel", c[1:0], cfg.third_sel)
         src = ~src;
         #1;
         chk_out(3'h0);
         `CHK("divider one src off", 1'b0, d1s)
         `CHK("divider four src off", 1'b0, d4s)
      end
      src = 11'h7FF;
   endtask : t_select

   task automatic t_stop;
      host_u.wr_byte(OCR_OUTSEL_OFS, 8'hA1);
      host_u.wr_byte(OCR_PWRDIV_OFS, 8'h9B);
      stp = 1'b1;
      tick(4);
      chk_out(3'h0);
      host_u.rmw_byte(OCR_PWRDIV_OFS, 8'h40, 8'h40);
      tick(2);
      chk_out(3'h2);
      host_u.rmw_byte(OCR_PWRDIV_OFS, 8'h20, 8'h20);
      tick(2);
      chk_out(3'h6);
      host_u.rmw_byte(OCR_PWRDIV_OFS, 8'h08, 8'h00);
      tick(2);
      chk_out(3'h7);
      host_u.rmw_byte(OCR_PWRDIV_OFS, 8'h40, 8'h00);
      tick(2);
      chk_out(3'h1);
      stp = 1'b0;
      tick(4);
      chk_out(3'h7);
   endtask : t_stop

   task automatic t_oe;
      oe2 = 1'b0;
      oe3 = 1'b0;
      tick(4);
      chk_out(3'h7);
      host_u.rmw_byte(OCR_PWRDIV_OFS, 8'h04, 8'h04);
      tick(2);
      chk_out(3'h1);
      oe2 = 1'b1;
      tick(4);
      chk_out(3'h3);
      oe3 = 1'b1;
      tick(4);
      chk_out(3'h7);
   endtask : t_oe

   task automatic t_pdn;
      host_u.rmw_byte(OCR_PWRDIV_OFS, 8'h80, 8'h00);
      tick(2);
      chk_out(3'h0);
      `CHK("pdn pin", 1'b0, pdn)
      `CHK("pdn cfg", 1'b0, cfg.chip_power_down_n)
      host_u.rmw_byte(OCR_PWRDIV_OFS, 8'h80, 8'h80);
      tick(2);
      chk_out(3'h7);
   endtask : t_pdn

   task automatic conclude;
      $display("comparisons %0d fails %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude

   initial begin
      nrst = 1'b0;
      oe2 = 1'b1;
      oe3 = 1'b1;
      stp = 1'b0;
      src = 11'h000;
      tick(12);
      nrst = 1'b1;
      t_reset();
      t_select();
      t_stop();
      t_oe();
      t_pdn();
      conclude();
   end

   // The sequence needs well under a thousand cycles.
   initial begin
      #(5000 * 100);
      fails++;
      conclude();
   end
endmodule : output_clock_routing_ctrl_test
